// >>> src/fga_alert_regs.sv
// fuel gauge alert/status register bank behind an ahb-lite slave port
// assumes: measurements arrive synchronous to hclk; single word transfers
//
// Overview of operation
// - voltage limit upper byte is maximum in 20mV steps, 0xff disables it
// - voltage limit lower byte is minimum in 20mV steps, 0x00 disables it
// - status bit 12 set while cell voltage reading exceeds maximum limit
// - status bit 8 set while cell voltage reading is below minimum limit
// - bit 13 set above maximum temperature limit, bit 9 below minimum
// - status bit 14 set when charge level rises above maximum limit
// - status bit 10 set when charge level falls below minimum limit
// - bit 15 latches battery removal until software clears it
// - bit 11 latches battery insertion until software clears it
// - bit 3 reads 1 while battery removed, 0 present, 0 at power-up
// - bit 1 set by any power-on reset, 1 after power-up, software clears
// - bit 7 set on each 1% change of charge level, 0 at power-up
// - bit 6 set for hot thermistor, 0 at power-up
// - bit 4 set when system current exceeds maximum overcurrent limit
// - bit 0 set when minimum system-current threshold exceeded
// - alert, insertion and removal bits read 0 after power-up
// - smart temp upper byte is warm limit in 1C steps, 0x7f disables
// - smart temp lower byte is cool limit in 1C steps, 0x80 disables
// - config bit 5 set disables standard temperature adjustments
// - config bit 4 picks voltage estimate (1) or mixed estimate (0)
// - config bit 1 enables smart charging
// - config bit 0 enables smart full detection
// - charge sticky 1 holds charge alerts, 0 auto-clears; resets to 0
// - temperature sticky 1 holds temp alerts, 0 auto-clears; resets to 1
// - voltage sticky 1 holds voltage alerts, 0 auto-clears; resets to 0
`timescale 1ns/1ps
`include "fga_map.svh"

module fga_alert_regs (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        clk_en,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic        sw_por,
	input  wire logic [7:0]  cell_voltage_reading,
	input  wire logic [7:0]  temperature_reading,
	input  wire logic [7:0]  mixed_charge_estimate,
	input  wire logic [7:0]  voltage_charge_estimate,
	input  wire logic        battery_absent,
	input  wire logic        thermistor_hot,
	input  wire logic        isys_over_max,
	input  wire logic        isys_over_min,
	output logic             temp_adjust_disable,
	output logic             voltage_estimate_select,
	output logic             smart_charging_enable,
	output logic             smart_full_enable,
	output logic      [7:0]  warm_limit,
	output logic      [7:0]  cool_limit,
	output logic      [7:0]  smart_charge_level
);
	import fga_pkg::*;

	fga_state_t s_q;
	fga_state_t s_d;

	// ------------------------------------------------------------
	// comparators
	// ------------------------------------------------------------
	logic [7:0] soc;
	logic       v_hi, v_lo, t_hi, t_lo, c_hi, c_lo;
	logic       step, rem_ev, ins_ev;
	logic       setup, wr_hit;
	logic [15:0] wmask, wdat;

	always_comb begin
		soc  = mixed_charge_estimate;
		v_hi = (s_q.vlim[15:8] != `FGA_VMAX_OFF) &&
		       (cell_voltage_reading > s_q.vlim[15:8]);
		v_lo = (s_q.vlim[7:0] != `FGA_VMIN_OFF) &&
		       (cell_voltage_reading < s_q.vlim[7:0]);
		// temperature is two's complement, 1C per lsb
		t_hi = (s_q.tlim[15:8] != `FGA_TMAX_OFF) &&
		       ($signed(temperature_reading) > $signed(s_q.tlim[15:8]));
		t_lo = (s_q.tlim[7:0] != `FGA_TMIN_OFF) &&
		       ($signed(temperature_reading) < $signed(s_q.tlim[7:0]));
		c_hi = (s_q.slim[15:8] != `FGA_SMAX_OFF) && (soc > s_q.slim[15:8]);
		c_lo = (s_q.slim[7:0] != `FGA_SMIN_OFF) && (soc < s_q.slim[7:0]);
		step = s_q.soc_seen && (soc != s_q.last_soc);
		rem_ev = battery_absent && !s_q.bat_prev;
		ins_ev = !battery_absent && s_q.bat_prev;
	end

	// ------------------------------------------------------------
	// state update
	// ------------------------------------------------------------
	always_comb begin
		s_d   = s_q;
		setup = hsel && hready && htrans[1];
		wr_hit = s_q.dph_wr;
		wdat  = hwdata[15:0];
		wmask = 16'h0000;
		if (clk_en) begin
			// data phase: register writes
			if (wr_hit) begin
				case (s_q.dph_idx)
					`FGA_IDX_FLAGS:   wmask = ~wdat;
					`FGA_IDX_VLIM:    s_d.vlim = wdat;
					`FGA_IDX_TLIM:    s_d.tlim = wdat;
					`FGA_IDX_SLIM:    s_d.slim = wdat;
					`FGA_IDX_STICKY:  s_d.sticky = wdat & `FGA_STICKY_MASK;
					`FGA_IDX_SC_TEMP: s_d.sc_temp = wdat;
					`FGA_IDX_SC_CFG:  s_d.sc_cfg = wdat & `FGA_SC_CFG_MASK;
					default: ;
				endcase
			end
			// software clear by writing 0, hardware set wins below
			s_d.flags = s_q.flags & ~wmask;

			// auto-clear when not sticky and back inside limits
			if (!s_q.sticky[`FGA_B_STK_VOLT]) begin
				s_d.flags[`FGA_B_VMAX] = 1'b0;
				s_d.flags[`FGA_B_VMIN] = 1'b0;
			end
			if (!s_q.sticky[`FGA_B_STK_TEMP]) begin
				s_d.flags[`FGA_B_TMAX] = 1'b0;
				s_d.flags[`FGA_B_TMIN] = 1'b0;
			end
			if (!s_q.sticky[`FGA_B_STK_CHG]) begin
				s_d.flags[`FGA_B_SMAX] = 1'b0;
				s_d.flags[`FGA_B_SMIN] = 1'b0;
			end
			// level-following bits
			s_d.flags[`FGA_B_MAX_ISYS] = isys_over_max;
			s_d.flags[`FGA_B_MIN_ISYS] = isys_over_min;
			s_d.flags[`FGA_B_BAT_STATE] = battery_absent;
			s_d.flags[`FGA_B_THM_HOT] = thermistor_hot;
			// hardware sets
			if (v_hi) s_d.flags[`FGA_B_VMAX] = 1'b1;
			if (v_lo) s_d.flags[`FGA_B_VMIN] = 1'b1;
			if (t_hi) s_d.flags[`FGA_B_TMAX] = 1'b1;
			if (t_lo) s_d.flags[`FGA_B_TMIN] = 1'b1;
			if (c_hi) s_d.flags[`FGA_B_SMAX] = 1'b1;
			if (c_lo) s_d.flags[`FGA_B_SMIN] = 1'b1;
			if (step) s_d.flags[`FGA_B_CHG_STEP] = 1'b1;
			if (rem_ev) s_d.flags[`FGA_B_REM] = 1'b1;
			if (ins_ev) s_d.flags[`FGA_B_INS] = 1'b1;
			// por_pend carries the reset event into the first live cycle
			if (sw_por || s_q.por_pend) s_d.flags[`FGA_B_POR] = 1'b1;
			s_d.flags[2] = 1'b0;
			s_d.flags[5] = 1'b0;
			s_d.por_pend = 1'b0;
			s_d.last_soc = soc;
			s_d.soc_seen = 1'b1;
			s_d.bat_prev = battery_absent;

			// address phase capture; read data prepared for data phase
			s_d.dph_wr  = setup && hwrite;
			s_d.dph_rd  = setup && !hwrite;
			s_d.dph_idx = haddr[9:2];
			s_d.rdata   = 32'h0000_0000;
			if (setup && !hwrite) begin
				case (haddr[9:2])
					`FGA_IDX_FLAGS:   s_d.rdata = {16'h0000, s_d.flags};
					`FGA_IDX_VLIM:    s_d.rdata = {16'h0000, s_d.vlim};
					`FGA_IDX_TLIM:    s_d.rdata = {16'h0000, s_d.tlim};
					`FGA_IDX_SLIM:    s_d.rdata = {16'h0000, s_d.slim};
					`FGA_IDX_STICKY:  s_d.rdata = {16'h0000, s_d.sticky};
					`FGA_IDX_SC_TEMP: s_d.rdata = {16'h0000, s_d.sc_temp};
					`FGA_IDX_SC_CFG:  s_d.rdata = {16'h0000, s_d.sc_cfg};
					default:          s_d.rdata = 32'h0000_0000;
				endcase
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_q.flags    <= `FGA_RST_FLAGS;
			s_q.vlim     <= `FGA_RST_VLIM;
			s_q.tlim     <= `FGA_RST_TLIM;
			s_q.slim     <= `FGA_RST_SLIM;
			s_q.sticky   <= `FGA_RST_STICKY;
			s_q.sc_temp  <= `FGA_RST_SC_TEMP;
			s_q.sc_cfg   <= `FGA_RST_SC_CFG;
			s_q.dph_wr   <= 1'b0;
			s_q.dph_rd   <= 1'b0;
			s_q.dph_idx  <= 8'h00;
			s_q.rdata    <= 32'h0000_0000;
			s_q.last_soc <= 8'h00;
			s_q.soc_seen <= 1'b0;
			s_q.bat_prev <= 1'b0;
			s_q.por_pend <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	// zero wait states: hreadyout flop is 0 in reset, then 1 from the first enabled cycle
	logic ready_q;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ready_q <= 1'b0;
		end else if (clk_en) begin
			ready_q <= 1'b1;
		end
	end

	assign hreadyout = ready_q;
	assign hresp     = 1'b0;
	assign hrdata    = s_q.rdata;
	assign temp_adjust_disable     = s_q.sc_cfg[`FGA_B_TADJ_DIS];
	assign voltage_estimate_select = s_q.sc_cfg[`FGA_B_VEST_SEL];
	assign smart_charging_enable   = s_q.sc_cfg[`FGA_B_SC_EN];
	assign smart_full_enable       = s_q.sc_cfg[`FGA_B_SF_EN];
	assign warm_limit = s_q.sc_temp[15:8];
	assign cool_limit = s_q.sc_temp[7:0];

	// selected estimate registered so the output comes from a flop
	logic [7:0] sel_q;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sel_q <= 8'h00;
		end else if (clk_en) begin
			sel_q <= s_q.sc_cfg[`FGA_B_VEST_SEL] ? voltage_charge_estimate
			                                     : mixed_charge_estimate;
		end
	end
	assign smart_charge_level = sel_q;

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	vmax_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
		clk_en && v_hi |=> s_q.flags[`FGA_B_VMAX])
		else $error("voltage max flag not set");
	vmin_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
		clk_en && v_lo |=> s_q.flags[`FGA_B_VMIN])
		else $error("voltage min flag not set");
	vmax_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
		clk_en && s_q.vlim[15:8] == `FGA_VMAX_OFF && !s_q.sticky[12]
		|=> !s_q.flags[`FGA_B_VMAX])
		else $error("disabled max voltage alert set");
	tmax_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
		clk_en && t_hi |=> s_q.flags[`FGA_B_TMAX])
		else $error("temp max flag not set");
	soc_auto_a: assert property (@(posedge hclk) disable iff (!hresetn)
		clk_en && !s_q.sticky[`FGA_B_STK_CHG] && !c_hi
		|=> !s_q.flags[`FGA_B_SMAX])
		else $error("charge max flag did not auto clear");
	rem_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
		s_q.flags[`FGA_B_REM] && !(wr_hit && s_q.dph_idx == 8'h00)
		|=> s_q.flags[`FGA_B_REM])
		else $error("removal flag dropped without clear");
	ins_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
		clk_en && ins_ev |=> s_q.flags[`FGA_B_INS])
		else $error("insertion flag not set");
	bat_state_a: assert property (@(posedge hclk) disable iff (!hresetn)
		clk_en |=> s_q.flags[`FGA_B_BAT_STATE] == $past(battery_absent))
		else $error("battery state bit wrong");

	vmin_off_a: assert property (@(posedge hclk)
		disable iff (!hresetn)
		clk_en && s_q.vlim[7:0] == `FGA_VMIN_OFF && !s_q.sticky[12]
		|=> !s_q.flags[`FGA_B_VMIN])
		else $error("disabled min voltage alert set");

	vmax_auto_a: assert property (@(posedge hclk)
		disable iff (!hresetn)
		clk_en && !s_q.sticky[`FGA_B_STK_VOLT] && !v_hi
		|=> !s_q.flags[`FGA_B_VMAX])
		else $error("voltage max flag did not auto clear");

	tmin_set_a: assert property (@(posedge hclk)
		disable iff (!hresetn)
		clk_en && t_lo |=> s_q.flags[`FGA_B_TMIN])
		else $error("temp min flag not set");

	tmax_hold_a: assert property (@(posedge hclk)
		disable iff (!hresetn)
		clk_en && s_q.sticky[`FGA_B_STK_TEMP] && s_q.flags[`FGA_B_TMAX] &&
		!(wr_hit && s_q.dph_idx == `FGA_IDX_FLAGS) |=> s_q.flags[`FGA_B_TMAX])
		else $error("sticky temp max flag dropped");

	smax_set_a: assert property (@(posedge hclk)
		disable iff (!hresetn)
		clk_en && c_hi |=> s_q.flags[`FGA_B_SMAX])
		else $error("charge max flag not set");

	smin_set_a: assert property (@(posedge hclk)
		disable iff (!hresetn)
		clk_en && c_lo |=> s_q.flags[`FGA_B_SMIN])
		else $error("charge min flag not set");

	rem_set_a: assert property (@(posedge hclk)
		disable iff (!hresetn)
		clk_en && rem_ev |=> s_q.flags[`FGA_B_REM])
		else $error("removal flag not set");

	ins_hold_a: assert property (@(posedge hclk)
		disable iff (!hresetn)
		s_q.flags[`FGA_B_INS] && !(wr_hit && s_q.dph_idx == `FGA_IDX_FLAGS)
		|=> s_q.flags[`FGA_B_INS])
		else $error("insertion flag dropped without clear");

	por_set_a: assert property (@(posedge hclk)
		disable iff (!hresetn)
		clk_en && sw_por |=> s_q.flags[`FGA_B_POR])
		else $error("power-on flag not set");

	step_set_a: assert property (@(posedge hclk)
		disable iff (!hresetn)
		clk_en && step |=> s_q.flags[`FGA_B_CHG_STEP])
		else $error("charge step flag not set");

	thm_hot_a: assert property (@(posedge hclk)
		disable iff (!hresetn)
		clk_en |=> s_q.flags[`FGA_B_THM_HOT] == $past(thermistor_hot))
		else $error("thermistor hot bit wrong");

	isys_max_a: assert property (@(posedge hclk)
		disable iff (!hresetn)
		clk_en |=> s_q.flags[`FGA_B_MAX_ISYS] == $past(isys_over_max))
		else $error("max system current bit wrong");

	isys_min_a: assert property (@(posedge hclk)
		disable iff (!hresetn)
		clk_en |=> s_q.flags[`FGA_B_MIN_ISYS] == $past(isys_over_min))
		else $error("min system current bit wrong");

	cfg_tadj_a: assert property (@(posedge hclk)
		disable iff (!hresetn)
		clk_en && wr_hit && s_q.dph_idx == `FGA_IDX_SC_CFG
		|=> temp_adjust_disable == $past(hwdata[`FGA_B_TADJ_DIS]))
		else $error("temp adjust disable not written");

	cfg_vsel_a: assert property (@(posedge hclk)
		disable iff (!hresetn)
		clk_en && wr_hit && s_q.dph_idx == `FGA_IDX_SC_CFG
		|=> voltage_estimate_select == $past(hwdata[`FGA_B_VEST_SEL]))
		else $error("estimate select not written");

	cfg_scen_a: assert property (@(posedge hclk)
		disable iff (!hresetn)
		clk_en && wr_hit && s_q.dph_idx == `FGA_IDX_SC_CFG
		|=> smart_charging_enable == $past(hwdata[`FGA_B_SC_EN]))
		else $error("smart charging enable not written");

	cfg_sfen_a: assert property (@(posedge hclk)
		disable iff (!hresetn)
		clk_en && wr_hit && s_q.dph_idx == `FGA_IDX_SC_CFG
		|=> smart_full_enable == $past(hwdata[`FGA_B_SF_EN]))
		else $error("smart full enable not written");

	rdata_idle_a: assert property (@(posedge hclk)
		disable iff (!hresetn)
		!s_q.dph_rd |-> hrdata == 32'h0000_0000)
		else $error("read data outside read data phase");

	flag_clear_a: assert property (@(posedge hclk)
		disable iff (!hresetn)
		clk_en && wr_hit && s_q.dph_idx == `FGA_IDX_FLAGS &&
		!hwdata[`FGA_B_REM] && !rem_ev |=> !s_q.flags[`FGA_B_REM])
		else $error("removal flag not cleared by write");
endmodule : fga_alert_regs

// >>> src/fga_map.svh
// fuel gauge alert/status block: register offsets, field positions, resets
// assumes: included by the design file and the bench by bare name
`ifndef FGA_MAP_SVH
`define FGA_MAP_SVH

// register indices (printed offsets), byte address is four times the index
`define FGA_IDX_FLAGS        8'h00
`define FGA_IDX_VLIM         8'h01
`define FGA_IDX_TLIM         8'h02
`define FGA_IDX_SLIM         8'h03
`define FGA_IDX_STICKY       8'h1d
`define FGA_IDX_SC_TEMP      8'hb2
`define FGA_IDX_SC_CFG       8'hdb

// status bit positions
`define FGA_B_MIN_ISYS       0
`define FGA_B_POR            1
`define FGA_B_BAT_STATE      3
`define FGA_B_MAX_ISYS       4
`define FGA_B_THM_HOT        6
`define FGA_B_CHG_STEP       7
`define FGA_B_VMIN           8
`define FGA_B_TMIN           9
`define FGA_B_SMIN           10
`define FGA_B_INS            11
`define FGA_B_VMAX           12
`define FGA_B_TMAX           13
`define FGA_B_SMAX           14
`define FGA_B_REM            15

// sticky-control register bit positions
`define FGA_B_STK_CHG        14
`define FGA_B_STK_TEMP       13
`define FGA_B_STK_VOLT       12

// smart-charge config bit positions
`define FGA_B_TADJ_DIS       5
`define FGA_B_VEST_SEL       4
`define FGA_B_SC_EN          1
`define FGA_B_SF_EN          0

// reset values and write masks
`define FGA_RST_FLAGS        16'h0002
`define FGA_RST_VLIM         16'hff00
`define FGA_RST_TLIM         16'h7f80
`define FGA_RST_SLIM         16'hff00
`define FGA_RST_STICKY       16'h2000
`define FGA_RST_SC_TEMP      16'h7f80
`define FGA_RST_SC_CFG       16'h0000
`define FGA_SC_CFG_MASK      16'h0033
`define FGA_STICKY_MASK      16'h7000

// limit disable codes
`define FGA_VMAX_OFF         8'hff
`define FGA_VMIN_OFF         8'h00
`define FGA_TMAX_OFF         8'h7f
`define FGA_TMIN_OFF         8'h80
`define FGA_SMAX_OFF         8'hff
`define FGA_SMIN_OFF         8'h00

`endif

// >>> src/fga_pkg.sv
// fuel gauge alert/status block: shared types
// assumes: fga_map.svh holds every number
package fga_pkg;
	typedef struct packed {
		logic [15:0] flags;
		logic [15:0] vlim;
		logic [15:0] tlim;
		logic [15:0] slim;
		logic [15:0] sticky;
		logic [15:0] sc_temp;
		logic [15:0] sc_cfg;
		logic        dph_wr;
		logic        dph_rd;
		logic [7:0]  dph_idx;
		logic [31:0] rdata;
		logic [7:0]  last_soc;
		logic        soc_seen;
		logic        bat_prev;
		logic        por_pend;
	} fga_state_t;
endpackage : fga_pkg

// >>> verif/fuel_gauge_alert_status_tb.sv
// fuel gauge alert/status bench: register model and flag checks over ahb-lite
// assumes: fga_alert_regs is the only slave, byte address is index times four
`timescale 1ns/1ps
`include "fga_map.svh"

module fuel_gauge_alert_status_tb;
	import fga_pkg::*;

	logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, sw_por;
	logic        absent, thot, imax, imin, tad, vsel, scen, sfen;
	logic [1:0]  htrans;
	logic [31:0] haddr, hwdata, hrdata;
	logic [7:0]  cv, tr, mix, vest, warm, cool, scl;
	logic [15:0] lf;
	logic [15:0] m [logic [7:0]];
	int          n_errors, n_checks, cyc;

	fga_alert_regs i_dut (
		.hclk(hclk), .hresetn(hresetn), .clk_en(1'b1), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .sw_por(sw_por),
		.cell_voltage_reading(cv), .temperature_reading(tr),
		.mixed_charge_estimate(mix), .voltage_charge_estimate(vest),
		.battery_absent(absent), .thermistor_hot(thot),
		.isys_over_max(imax), .isys_over_min(imin),
		.temp_adjust_disable(tad), .voltage_estimate_select(vsel),
		.smart_charging_enable(scen), .smart_full_enable(sfen),
		.warm_limit(warm), .cool_limit(cool), .smart_charge_level(scl)
	);

	// ----------------------------------------------------------------
	// clock, watchdog and verdict
	// ----------------------------------------------------------------
	always #20 hclk = ~hclk;

	// the whole run needs well under two thousand cycles
	always @(posedge hclk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			n_errors++;
			stop_test();
		end
	end

	task stop_test;
		if (n_errors == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : stop_test

	function logic [15:0] nxt(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction : nxt

	task chk(input string what, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, e, g);
		end
	endtask : chk

	// ----------------------------------------------------------------
	// bus master and register model
	// ----------------------------------------------------------------
	task bus(input logic w, input logic [7:0] idx, input logic [15:0] wd,
		output logic [31:0] rd_q);
		@(posedge hclk);
		hsel   <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr  <= {22'h0, idx, 2'h0};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {16'h0, wd};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd_q = hrdata;
	endtask : bus

	// a zero clears a latched flag; level-driven bits ignore writes
	task wr(input logic [7:0] idx, input logic [15:0] d);
		logic [31:0] r;
		bus(1'b1, idx, d, r);
		if (idx == `FGA_IDX_FLAGS)
			m[idx] = m[idx] & (d | 16'h007d);
		else if (idx == `FGA_IDX_SC_CFG)
			m[idx] = d & `FGA_SC_CFG_MASK;
		else if (idx == `FGA_IDX_STICKY)
			m[idx] = d & `FGA_STICKY_MASK;
		else if (m.exists(idx))
			m[idx] = d;
	endtask : wr

	task rd(input logic [7:0] idx);
		logic [31:0] r;
		bus(1'b0, idx, 16'h0, r);
		chk($sformatf("reg %h", idx), m.exists(idx) ? {16'h0, m[idx]} : 0, r);
		chk("hresp", 32'h0, {31'h0, hresp});
	endtask : rd

	// model state after any reset
	task mrst;
		m[`FGA_IDX_FLAGS]   = `FGA_RST_FLAGS;
		m[`FGA_IDX_VLIM]    = `FGA_RST_VLIM;
		m[`FGA_IDX_TLIM]    = `FGA_RST_TLIM;
		m[`FGA_IDX_SLIM]    = `FGA_RST_SLIM;
		m[`FGA_IDX_STICKY]  = `FGA_RST_STICKY;
		m[`FGA_IDX_SC_TEMP] = `FGA_RST_SC_TEMP;
		m[`FGA_IDX_SC_CFG]  = `FGA_RST_SC_CFG;
	endtask : mrst

	// flags settle one cycle after their cause; three leave margin
	task fl(input logic [15:0] e);
		m[`FGA_IDX_FLAGS] = e;
		repeat (3) @(posedge hclk);
		rd(`FGA_IDX_FLAGS);
	endtask : fl

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	logic [7:0]  vt [5] = '{8'h90, 8'h80, 8'h64, 8'h30, 8'h40};
	logic [15:0] ve [5] = '{16'h1000, 16'h0, 16'h0, 16'h0100, 16'h0};

	initial begin
		{hclk, hresetn, hsel, hwrite, sw_por, absent, thot, imax, imin} = 0;
		{htrans, haddr, hwdata, cyc, n_errors, n_checks} = 0;
		{cv, tr, mix, vest, lf} = {8'h64, 8'h19, 8'h32, 8'h3c, 16'h0004};
		mrst();
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		foreach (m[i]) rd(i);
		rd(8'h05);
		wr(`FGA_IDX_FLAGS, 16'h0);
		fl(16'h0);
		sw_por <= 1'b1;
		@(posedge hclk) sw_por <= 1'b0;
		fl(16'h0002);
		wr(`FGA_IDX_FLAGS, 16'h0);
		for (int i = 0; i < 6; i++) begin
			lf = nxt(lf);
			vest <= lf[15:8];
			wr(`FGA_IDX_SC_CFG, {lf[15:5], i[0], lf[3:0]});
			wr(`FGA_IDX_SC_TEMP, ~lf);
			rd(`FGA_IDX_SC_CFG);
			rd(`FGA_IDX_SC_TEMP);
			chk("cfg", m[`FGA_IDX_SC_CFG], {tad, vsel, 2'h0, scen, sfen});
			chk("temp lim", m[`FGA_IDX_SC_TEMP], {warm, cool});
			chk("level", i[0] ? vest : mix, scl);
		end
		wr(`FGA_IDX_VLIM, 16'h8040);
		for (int i = 0; i < 5; i++) begin
			cv <= vt[i];
			fl(ve[i]);
		end
		wr(`FGA_IDX_STICKY, 16'h3000);
		cv <= 8'h90;
		fl(16'h1000);
		cv <= 8'h64;
		fl(16'h1000);
		wr(`FGA_IDX_FLAGS, 16'hefff);
		fl(16'h0);
		wr(`FGA_IDX_TLIM, 16'h2805);
		tr <= 8'h32;
		fl(16'h2000);
		tr <= 8'h19;
		fl(16'h2000);
		wr(`FGA_IDX_FLAGS, 16'hdfff);
		tr <= 8'hf6;
		fl(16'h0200);
		tr <= 8'h19;
		wr(`FGA_IDX_FLAGS, 16'hfdff);
		fl(16'h0);
		wr(`FGA_IDX_SLIM, 16'h5a0a);
		mix <= 8'h5f;
		fl(16'h4080);
		mix <= 8'h32;
		fl(16'h0080);
		wr(`FGA_IDX_FLAGS, 16'hff7f);
		mix <= 8'h05;
		fl(16'h0480);
		mix <= 8'h32;
		wr(`FGA_IDX_FLAGS, 16'hff7f);
		fl(16'h0);
		absent <= 1'b1;
		fl(16'h8008);
		wr(`FGA_IDX_FLAGS, 16'h7fff);
		fl(16'h0008);
		absent <= 1'b0;
		fl(16'h0800);
		wr(`FGA_IDX_FLAGS, 16'hf7ff);
		{thot, imax, imin} <= 3'h7;
		fl(16'h0051);
		wr(`FGA_IDX_FLAGS, 16'h0);
		fl(16'h0051);
		{thot, imax, imin} <= 3'h0;
		fl(16'h0);
		// mid-run reset brings every register back to its power-up value
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		mrst();
		foreach (m[i]) rd(i);
		stop_test();
	end
endmodule : fuel_gauge_alert_status_tb
